// file: usart_spi_master_flags_irq_test.sv
`timescale 1ns/100ps
`include "usmf_params.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, a, b); end end
module usart_spi_master_flags_irq_test;
    import usmf_pkg::*;
    logic pclk = 1'b0;
    logic link_clk = 1'b0;
    logic presetn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic global_irq_enable = 1'b0;
    logic tx_irq_taken = 1'b0;
    logic spi_miso;
    logic spi_sck;
    logic spi_mosi;
    logic spi_cs_n;
    logic rx_irq;
    logic tx_irq;
    logic empty_irq;
    logic [7:0] slave_got;
    logic [7:0] slave_frames;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int checks = 0;

    always #4 pclk = ~pclk;
    initial begin
        #3;
        forever #16 link_clk = ~link_clk;
    end

    usmf_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_irq_enable(global_irq_enable), .tx_irq_taken(tx_irq_taken), .link_clk(link_clk),
        .spi_miso(spi_miso), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_cs_n(spi_cs_n),
        .rx_irq(rx_irq), .tx_irq(tx_irq), .empty_irq(empty_irq));

    usmf_spi_slave i_slave (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .reply(8'ha5),
        .spi_miso(spi_miso), .got(slave_got), .frames(slave_frames));

    // ****************************************************************
    // Bus and checking tasks.
    // ****************************************************************
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        `CHK(pready, 1'b1)
        rd = prdata;
        err = pslverr;
        `CHK(err, (a != `USMF_OFS_STATUS_A && a != `USMF_OFS_CONTROL_B && a != `USMF_OFS_DATA))
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        `CHK(rd, exp)
    endtask : rd_chk

    task irq_chk(input logic [2:0] exp);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        `CHK({rx_irq, tx_irq, empty_irq}, exp)
    endtask : irq_chk

    task wait_frames(input logic [7:0] k);
        int n;
        n = 0;
        while (slave_frames !== k && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        `CHK(slave_frames, k)
        repeat (8) @(posedge pclk);
    endtask : wait_frames

    task note(input string s);
        $display("test %s finished", s);
    endtask : note

    task test_done;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    initial begin
        #100000;
        n_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        test_done();
    end

    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial begin
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`USMF_OFS_STATUS_A, 32'h20);
        rd_chk(`USMF_OFS_CONTROL_B, 32'h00);
        rd_chk(12'h00c, 32'h0);
        apb(1'b1, `USMF_OFS_STATUS_A, 32'h0);
        rd_chk(`USMF_OFS_STATUS_A, 32'h20);
        irq_chk(3'b000);
        note("reset");
        apb(1'b1, `USMF_OFS_CONTROL_B, 32'he0);
        irq_chk(3'b000);
        @(posedge pclk);
        global_irq_enable <= 1'b1;
        irq_chk(3'b001);
        apb(1'b1, `USMF_OFS_CONTROL_B, 32'h00);
        irq_chk(3'b000);
        note("gating");
        apb(1'b1, `USMF_OFS_CONTROL_B, 32'hf0);
        apb(1'b1, `USMF_OFS_DATA, 32'h3c);
        apb(1'b1, `USMF_OFS_DATA, 32'hc3);
        rd_chk(`USMF_OFS_STATUS_A, 32'h00);
        irq_chk(3'b000);
        apb(1'b1, `USMF_OFS_DATA, 32'h77);
        wait_frames(8'd2);
        `CHK(slave_got, 8'hc3)
        rd_chk(`USMF_OFS_STATUS_A, 32'he0);
        irq_chk(3'b111);
        rd_chk(`USMF_OFS_DATA, 32'ha5);
        rd_chk(`USMF_OFS_STATUS_A, 32'h60);
        irq_chk(3'b011);
        repeat (320) @(posedge pclk);
        `CHK(slave_frames, 8'd2)
        note("traffic");
        apb(1'b1, `USMF_OFS_STATUS_A, 32'h40);
        rd_chk(`USMF_OFS_STATUS_A, 32'h20);
        irq_chk(3'b001);
        apb(1'b1, `USMF_OFS_DATA, 32'h5a);
        wait_frames(8'd3);
        `CHK(slave_got, 8'h5a)
        @(posedge pclk);
        global_irq_enable <= 1'b0;
        irq_chk(3'b000);
        @(posedge pclk);
        global_irq_enable <= 1'b1;
        irq_chk(3'b111);
        @(posedge pclk);
        tx_irq_taken <= 1'b1;
        @(posedge pclk);
        tx_irq_taken <= 1'b0;
        irq_chk(3'b101);
        apb(1'b1, `USMF_OFS_CONTROL_B, 32'he0);
        rd_chk(`USMF_OFS_STATUS_A, 32'h20);
        irq_chk(3'b001);
        rd_chk(`USMF_OFS_CONTROL_B, 32'he0);
        note("clearing");
        test_done();
    end
endmodule : usart_spi_master_flags_irq_test

// file: usmf_params.svh
`ifndef USMF_PARAMS_SVH
`define USMF_PARAMS_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define USMF_OFS_STATUS_A 12'h000
`define USMF_OFS_CONTROL_B 12'h004
`define USMF_OFS_DATA 12'h008

// ****************************************************************
// Field positions.
// ****************************************************************
`define USMF_BIT_RX_COMPLETE 7
`define USMF_BIT_TX_COMPLETE 6
`define USMF_BIT_BUF_EMPTY 5
`define USMF_BIT_RX_IRQ_EN 7
`define USMF_BIT_TX_IRQ_EN 6
`define USMF_BIT_EMPTY_IRQ_EN 5
`define USMF_BIT_RX_ENABLE 4

// ****************************************************************
// Reset values.
// ****************************************************************
`define USMF_RST_STATUS_A 8'h20
`define USMF_RST_CONTROL_B 8'h00

// ****************************************************************
// Timing counts.
// ****************************************************************
`define USMF_SCK_HALF 4
`define USMF_FRAME_BITS 8

`endif

// file: usmf_pkg.sv
// ****************************************************************
// Shared types.
// ****************************************************************
package usmf_pkg;
    typedef logic [7:0] usmf_byte_t;
    typedef enum logic {
        LS_IDLE,
        LS_SHIFT
    } usmf_link_state_t;
endpackage : usmf_pkg

// file: usmf_spi_link.sv
`timescale 1ns/100ps
`include "usmf_params.svh"
// ****************************************************************
// Link side shifter on the link clock.
// ****************************************************************
module usmf_spi_link (
    input wire logic link_clk,
    input wire logic presetn,
    input wire logic req_tgl,
    input wire usmf_pkg::usmf_byte_t tx_word,
    input wire logic spi_miso,
    output logic spi_sck,
    output logic spi_mosi,
    output logic spi_cs_n,
    output logic ack_tgl,
    output usmf_pkg::usmf_byte_t rx_word
);
    import usmf_pkg::*;

    logic req_s;
    logic miso_s;
    usmf_link_state_t state_q, state_d;
    usmf_byte_t shift_q, shift_d, in_q, in_d, rx_q, rx_d;
    logic [2:0] cnt_q, cnt_d;
    logic [1:0] div_q, div_d;
    logic sck_q, sck_d, cs_n_q, cs_n_d, ack_q, ack_d, req_prev_q;

    usmf_sync u_req_sync (.clk(link_clk), .rst_n(presetn), .d(req_tgl), .q(req_s));
    usmf_sync u_miso_sync (.clk(link_clk), .rst_n(presetn), .d(spi_miso), .q(miso_s));

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        in_d = in_q;
        rx_d = rx_q;
        cnt_d = cnt_q;
        div_d = div_q;
        sck_d = sck_q;
        cs_n_d = cs_n_q;
        ack_d = ack_q;
        case (state_q)
            LS_IDLE: begin
                if (req_s ^ req_prev_q) begin
                    shift_d = tx_word;
                    cs_n_d = 1'b0;
                    cnt_d = 3'h0;
                    div_d = 2'h0;
                    sck_d = 1'b0;
                    state_d = LS_SHIFT;
                end
            end
            LS_SHIFT: begin
                div_d = div_q + 2'h1;
                if (div_q == 2'(`USMF_SCK_HALF - 1)) begin
                    div_d = 2'h0;
                    sck_d = ~sck_q;
                    if (sck_q) begin
                        in_d = {in_q[6:0], miso_s};
                        shift_d = {shift_q[6:0], 1'b0};
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == 3'(`USMF_FRAME_BITS - 1)) begin
                            rx_d = {in_q[6:0], miso_s};
                            cs_n_d = 1'b1;
                            ack_d = ~ack_q;
                            state_d = LS_IDLE;
                        end
                    end
                end
            end
            default: begin
                state_d = LS_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            state_q <= LS_IDLE;
            shift_q <= 8'h00;
            in_q <= 8'h00;
            rx_q <= 8'h00;
            cnt_q <= 3'h0;
            div_q <= 2'h0;
            sck_q <= 1'b0;
            cs_n_q <= 1'b1;
            ack_q <= 1'b0;
            req_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            in_q <= in_d;
            rx_q <= rx_d;
            cnt_q <= cnt_d;
            div_q <= div_d;
            sck_q <= sck_d;
            cs_n_q <= cs_n_d;
            ack_q <= ack_d;
            req_prev_q <= req_s;
        end
    end

    assign spi_sck = sck_q;
    assign spi_mosi = shift_q[7];
    assign spi_cs_n = cs_n_q;
    assign ack_tgl = ack_q;
    assign rx_word = rx_q;
endmodule : usmf_spi_link

// file: usmf_spi_slave.sv
`timescale 1ns/100ps
// ****************************************************************
// Mode 0 serial slave that answers every frame with a fixed byte.
// ****************************************************************
module usmf_spi_slave (
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic [7:0] reply,
    output logic spi_miso,
    output logic [7:0] got,
    output logic [7:0] frames
);
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic in_frame;

    initial begin
        spi_miso = 1'b0;
        got = 8'h00;
        frames = 8'h00;
        in_frame = 1'b0;
        sh_in = 8'h00;
        sh_out = 8'h00;
    end

    // Loads the answer and presents its top bit before the first rise.
    always @(negedge spi_cs_n) begin
        in_frame = 1'b1;
        sh_out = reply;
        spi_miso = sh_out[7];
    end

    // Captures the master's data on the rising edge.
    always @(posedge spi_sck) begin
        if (!spi_cs_n) begin
            sh_in = {sh_in[6:0], spi_mosi};
        end
    end

    // Changes the answer line on the falling edge.
    always @(negedge spi_sck) begin
        if (!spi_cs_n) begin
            sh_out = {sh_out[6:0], 1'b0};
            spi_miso = sh_out[7];
        end
    end

    // Stores the frame and leaves the released line at a changed level.
    always @(posedge spi_cs_n) begin
        if (in_frame) begin
            in_frame = 1'b0;
            got = sh_in;
            frames = frames + 8'h01;
            spi_miso = ~spi_miso;
        end
    end
endmodule : usmf_spi_slave

// file: usmf_sync.sv
`timescale 1ns/100ps
// ****************************************************************
// Two flip-flop level synchroniser.
// ****************************************************************
module usmf_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : usmf_sync

// file: usmf_top.sv
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "usmf_params.svh"
// Notes on behaviour
// - The buffer-empty flag in status bit 5 reads one exactly while the transmit buffer can take a new byte.
// - After reset the buffer-empty flag is one.
// - The receive-complete request is raised only with its enable, the global enable and the flag all set.
// - The transmit-complete request is raised only with its enable, the global enable and the flag all set.
// - The buffer-empty request is raised only with its enable, the global enable and the flag all set.
// - The receive-complete flag shows unread received data and is flushed when the receiver is disabled.
// - The transmit-complete flag sets when a frame ends with nothing waiting, and clears on service or a written one.
module usmf_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic global_irq_enable,
    input wire logic tx_irq_taken,
    input wire logic link_clk,
    input wire logic spi_miso,
    output logic spi_sck,
    output logic spi_mosi,
    output logic spi_cs_n,
    output logic rx_irq,
    output logic tx_irq,
    output logic empty_irq
);
    import usmf_pkg::*;

    localparam logic [7:0] RST_STATUS = `USMF_RST_STATUS_A;

    // ****************************************************************
    // Address decode.
    // ****************************************************************
    function automatic logic is_reg(input logic [11:0] addr, input logic [11:0] ofs);
        is_reg = (addr[11:2] == ofs[11:2]);
    endfunction : is_reg

    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    usmf_byte_t ctrl_q, ctrl_d, hold_q, hold_d, word_q, word_d, rxbuf_q, rxbuf_d;
    logic full_q, full_d, busy_q, busy_d, req_q, req_d, rxc_q, rxc_d, txc_q, txc_d;
    logic rx_irq_q, rx_irq_d, tx_irq_q, tx_irq_d, empty_irq_q, empty_irq_d;
    logic ack_s, ack_prev_q, ack_evt, link_ack;
    usmf_byte_t link_rx;
    logic commit, wr_status, wr_ctrl, wr_data, rd_data, mapped;

    usmf_spi_link u_link (
        .link_clk(link_clk),
        .presetn(presetn),
        .req_tgl(req_q),
        .tx_word(word_q),
        .spi_miso(spi_miso),
        .spi_sck(spi_sck),
        .spi_mosi(spi_mosi),
        .spi_cs_n(spi_cs_n),
        .ack_tgl(link_ack),
        .rx_word(link_rx)
    );

    usmf_sync u_ack_sync (.clk(pclk), .rst_n(presetn), .d(link_ack), .q(ack_s));

    assign ack_evt = ack_s ^ ack_prev_q;
    assign commit = psel && penable && pready_q;
    assign mapped = is_reg(paddr, `USMF_OFS_STATUS_A) || is_reg(paddr, `USMF_OFS_CONTROL_B)
        || is_reg(paddr, `USMF_OFS_DATA);
    assign wr_status = commit && pwrite && is_reg(paddr, `USMF_OFS_STATUS_A);
    assign wr_ctrl = commit && pwrite && is_reg(paddr, `USMF_OFS_CONTROL_B);
    assign wr_data = commit && pwrite && is_reg(paddr, `USMF_OFS_DATA);
    assign rd_data = commit && !pwrite && is_reg(paddr, `USMF_OFS_DATA);

    // ****************************************************************
    // Bus answer.
    // ****************************************************************
    always_comb begin
        pready_d = psel && penable && !pready_q;
        pslverr_d = psel && penable && !pready_q && !mapped;
        prdata_d = 32'h00000000;
        if (psel && penable && !pready_q && !pwrite) begin
            if (is_reg(paddr, `USMF_OFS_STATUS_A)) begin
                prdata_d[`USMF_BIT_RX_COMPLETE] = rxc_q;
                prdata_d[`USMF_BIT_TX_COMPLETE] = txc_q;
                prdata_d[`USMF_BIT_BUF_EMPTY] = !full_q;
            end else if (is_reg(paddr, `USMF_OFS_CONTROL_B)) begin
                prdata_d[7:0] = ctrl_q;
            end else if (is_reg(paddr, `USMF_OFS_DATA)) begin
                prdata_d[7:0] = rxbuf_q;
            end
        end
    end

    // ****************************************************************
    // Buffer, flags and requests.
    // ****************************************************************
    always_comb begin
        ctrl_d = ctrl_q;
        hold_d = hold_q;
        word_d = word_q;
        rxbuf_d = rxbuf_q;
        full_d = full_q;
        busy_d = busy_q;
        req_d = req_q;
        rxc_d = rxc_q;
        txc_d = txc_q;
        if (wr_ctrl) begin
            ctrl_d = pwdata[7:0];
        end
        if (wr_data && !full_q) begin
            hold_d = pwdata[7:0];
            full_d = 1'b1;
        end
        if (full_q && !busy_q) begin
            word_d = hold_q;
            full_d = 1'b0;
            busy_d = 1'b1;
            req_d = ~req_q;
        end
        if (rd_data) begin
            rxc_d = 1'b0;
        end
        if (tx_irq_taken || (wr_status && pwdata[`USMF_BIT_TX_COMPLETE])) begin
            txc_d = 1'b0;
        end
        if (ack_evt) begin
            busy_d = 1'b0;
            if (ctrl_q[`USMF_BIT_RX_ENABLE]) begin
                rxbuf_d = link_rx;
                rxc_d = 1'b1;
            end
            if (!full_q) begin
                txc_d = 1'b1;
            end
        end
        if (!ctrl_d[`USMF_BIT_RX_ENABLE]) begin
            rxc_d = 1'b0;
        end
        rx_irq_d = ctrl_q[`USMF_BIT_RX_IRQ_EN] && global_irq_enable && rxc_q;
        tx_irq_d = ctrl_q[`USMF_BIT_TX_IRQ_EN] && global_irq_enable && txc_q;
        empty_irq_d = ctrl_q[`USMF_BIT_EMPTY_IRQ_EN] && global_irq_enable && !full_q;
    end

    // Status bits 4 to 0 have no storage, so written values are dropped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
            ctrl_q <= `USMF_RST_CONTROL_B;
            hold_q <= 8'h00;
            word_q <= 8'h00;
            rxbuf_q <= 8'h00;
            full_q <= !RST_STATUS[`USMF_BIT_BUF_EMPTY];
            busy_q <= 1'b0;
            req_q <= 1'b0;
            rxc_q <= RST_STATUS[`USMF_BIT_RX_COMPLETE];
            txc_q <= RST_STATUS[`USMF_BIT_TX_COMPLETE];
            rx_irq_q <= 1'b0;
            tx_irq_q <= 1'b0;
            empty_irq_q <= 1'b0;
            ack_prev_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            ctrl_q <= ctrl_d;
            hold_q <= hold_d;
            word_q <= word_d;
            rxbuf_q <= rxbuf_d;
            full_q <= full_d;
            busy_q <= busy_d;
            req_q <= req_d;
            rxc_q <= rxc_d;
            txc_q <= txc_d;
            rx_irq_q <= rx_irq_d;
            tx_irq_q <= tx_irq_d;
            empty_irq_q <= empty_irq_d;
            ack_prev_q <= ack_s;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign rx_irq = rx_irq_q;
    assign tx_irq = tx_irq_q;
    assign empty_irq = empty_irq_q;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_frame_done_idle;
        ack_evt && !full_q;
    endsequence

    sequence s_launch;
        full_q && !busy_q;
    endsequence

    a_apb_answer_two: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup ##1 (psel && penable) |=> pready_q)
        else $error("Slave did not answer in the second access cycle.");

    a_write_fills_buf: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_data && !full_q && !busy_q) |=> full_q ##1 (!full_q && busy_q))
        else $error("Written byte did not fill and then launch from the buffer.");

    a_launch_moves_word: assert property (@(posedge pclk) disable iff (!presetn)
        s_launch |=> (busy_q && !full_q && (req_q != $past(req_q)) && (word_q == $past(hold_q))))
        else $error("Buffer hand-off to the shifter failed.");

    a_reset_buf_empty: assert property (@(posedge pclk)
        !presetn |-> (!full_q && !busy_q))
        else $error("Buffer not empty during reset.");

    a_rx_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        rx_irq_q == $past(ctrl_q[`USMF_BIT_RX_IRQ_EN] && global_irq_enable && rxc_q))
        else $error("Receive request does not follow its gating terms.");

    a_tx_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(tx_irq_q) |-> $past(ctrl_q[`USMF_BIT_TX_IRQ_EN] && global_irq_enable && txc_q))
        else $error("Transmit request rose without all gating terms.");

    a_empty_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_q[`USMF_BIT_EMPTY_IRQ_EN] && global_irq_enable && !full_q) [*2] |-> empty_irq_q)
        else $error("Empty request missing while enabled and empty.");

    a_rx_flush_off: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_q[`USMF_BIT_RX_ENABLE] |-> !rxc_q)
        else $error("Receive flag set while the receiver is disabled.");

    a_rx_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_data && !ack_evt) |=> !rxc_q)
        else $error("Reading data did not clear the receive flag.");

    a_txc_set_done: assert property (@(posedge pclk) disable iff (!presetn)
        s_frame_done_idle |=> txc_q)
        else $error("Transmit-complete flag not set at frame end.");

    a_txc_clear_one: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_irq_taken && !ack_evt) |=> !txc_q)
        else $error("Serviced transmit-complete flag did not clear.");

    sequence s_frame_kept;
        ack_evt && ctrl_q[`USMF_BIT_RX_ENABLE] && !wr_ctrl;
    endsequence

    a_status_read_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready_q && !pwrite && is_reg(paddr, `USMF_OFS_STATUS_A))
        |=> ((prdata_q[`USMF_BIT_BUF_EMPTY] == !$past(full_q)) && (prdata_q[4:0] == 5'h00)))
        else $error("Status read does not show the buffer state.");

    a_full_refuses_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_data && full_q) |=> (hold_q == $past(hold_q)))
        else $error("Write into a full buffer was taken.");

    a_rx_set_frame: assert property (@(posedge pclk) disable iff (!presetn)
        s_frame_kept |=> (rxc_q && (rxbuf_q == $past(link_rx))))
        else $error("Received byte not stored with its flag.");

    a_txc_write_one: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_status && pwdata[`USMF_BIT_TX_COMPLETE] && !ack_evt) |=> !txc_q)
        else $error("Writing one did not clear the transmit flag.");

    a_global_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !global_irq_enable |=> !(rx_irq_q || tx_irq_q || empty_irq_q))
        else $error("Request raised with the global enable off.");

    a_tx_irq_low: assert property (@(posedge pclk) disable iff (!presetn)
        !txc_q |=> !tx_irq_q)
        else $error("Transmit request raised without its flag.");

    a_empty_irq_flag: assert property (@(posedge pclk) disable iff (!presetn)
        empty_irq_q |-> $past(global_irq_enable && !full_q))
        else $error("Empty request raised while the buffer was full.");

    a_ctrl_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> (ctrl_q == $past(pwdata[7:0])))
        else $error("Control write did not land.");

    a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready_q |=> !pready_q)
        else $error("Ready stood for more than one cycle.");

    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready_q && !mapped) |=> (pslverr_q && (prdata_q == 32'h00000000)))
        else $error("Unmapped access not refused.");

    a_mapped_no_err: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready_q && mapped) |=> (pready_q && !pslverr_q))
        else $error("Mapped access answered with an error.");

    a_req_steady: assert property (@(posedge pclk) disable iff (!presetn)
        !(full_q && !busy_q) |=> (req_q == $past(req_q)))
        else $error("Link request toggled without a launch.");
endmodule : usmf_top
